// ### reset_state_initializer.sv
// reset state initializer: merged reset, clock gating, vector load, register file
`timescale 1ns/1ps
module reset_state_initializer
  import reset_state_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire rst_src_s RST_SRC,
  input wire logic WDT_OPTION,
  input wire logic STANDBY,
  output clk_ctl_s CLK_CTL,
  output logic SYS_RESET,
  output logic RAM_PRESERVE,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [7:0] MEM_RDATA,
  output logic [15:0] PC,
  output logic PC_LOAD,
  output logic [39:0] PORT_OUT,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ****************************************************************
  // merged reset
  // ****************************************************************
  logic rst_any;
  logic rst_hard;
  logic rst_clr_cause;
  logic rst_d_r;
  logic ram_keep_r;

  assign rst_any = !NRST || !RST_SRC.pin_n || RST_SRC.power_on_clear || RST_SRC.wdt || RST_SRC.undervoltage_detector;
  // pin and power-on clear the cause flags; the block reset counts as power-on
  assign rst_clr_cause = !NRST || !RST_SRC.pin_n || RST_SRC.power_on_clear;
  assign rst_hard = rst_clr_cause || RST_SRC.wdt;
  assign SYS_RESET = rst_any;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rst_d_r <= 1'b1;
    end else begin
      rst_d_r <= rst_any;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ram_keep_r <= 1'b0;
    end else if (rst_any && !rst_d_r) begin
      ram_keep_r <= STANDBY;
    end
  end
  assign RAM_PRESERVE = ram_keep_r;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [15:0] w_data_r;
  logic [1:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_ok;
  logic [5:0] wr_idx;
  logic rd_fire;
  logic rd_ok;
  logic [5:0] rd_idx;
  logic rd_clr;
  logic [15:0] regs_r [NREG];

  assign S_AXI_AWREADY = !aw_got_r;
  assign S_AXI_WREADY = !w_got_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_idx = aw_addr_r[7:2];
  // whole address checked so any upper bit makes the access unmapped
  assign wr_ok = (32'(aw_addr_r) >> 2) < 32'(NREG);
  assign rd_fire = S_AXI_ARVALID && !rvalid_r;
  assign rd_idx = S_AXI_ARADDR[7:2];
  assign rd_ok = (32'(S_AXI_ARADDR) >> 2) < 32'(NREG);
  assign rd_clr = rd_fire && rd_ok && (rd_idx == IDX_RESET_CAUSE_FLAGS);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (S_AXI_AWVALID && !aw_got_r) begin
      aw_got_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      w_got_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (S_AXI_WVALID && !w_got_r) begin
      w_got_r <= 1'b1;
      w_data_r <= S_AXI_WDATA[15:0];
      w_strb_r <= S_AXI_WSTRB[1:0];
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= rd_ok ? {16'h0000, regs_r[rd_idx] & reg_mask(rd_idx)} : 32'h0000_0000;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // plain registers are held at reset values for as long as any reset lasts; cause, undervoltage and RAM retention registers are not,
  // so software writes during reset are dropped though still answered
  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    localparam logic [5:0] ID = 6'(gi);
    logic wr_hit;
    logic [15:0] wr_val;
    assign wr_hit = wr_fire && wr_ok && (wr_idx == ID);
    assign wr_val = {w_strb_r[1] ? w_data_r[15:8] : regs_r[gi][15:8],
                     w_strb_r[0] ? w_data_r[7:0] : regs_r[gi][7:0]} & reg_mask(ID);
    if (ID == IDX_RESET_CAUSE_FLAGS) begin : g_cause
      always_ff @(posedge CLK) begin
        if (rst_clr_cause) begin
          regs_r[gi] <= RV_ZERO;
        end else begin
          if (rd_clr) begin
            regs_r[gi] <= RV_ZERO;
          end
          if (RST_SRC.wdt) begin
            regs_r[gi][RESET_CAUSE_FLAGS_WDT_BIT] <= 1'b1;
          end
          if (RST_SRC.undervoltage_detector) begin
            regs_r[gi][RESET_CAUSE_FLAGS_LVI_BIT] <= 1'b1;
          end
        end
      end
    end else if (ID == IDX_UNDERVOLT_DETECT_CTRL || ID == IDX_UNDERVOLT_LEVEL_SELECT) begin : g_lvi
      always_ff @(posedge CLK) begin
        if (rst_hard) begin
          regs_r[gi] <= RV_ZERO;
        end else if (!rst_any && wr_hit) begin
          regs_r[gi] <= wr_val;
        end
      end
    end else if (ID == IDX_RAM_RETENTION_DETECT_CTRL) begin : g_keep
      always_ff @(posedge CLK) begin
        if (!rst_any && wr_hit) begin
          regs_r[gi] <= wr_val;
        end
      end
    end else begin : g_plain
      always_ff @(posedge CLK) begin
        if (rst_any) begin
          regs_r[gi] <= rst_val(ID, WDT_OPTION);
        end else if (wr_hit) begin
          regs_r[gi] <= wr_val;
        end
      end
    end
  end

  for (genvar gp = 0; gp < 5; gp++) begin : g_port
    assign PORT_OUT[gp*8 +: 8] = regs_r[32'(IDX_PORT0) + gp][7:0];
  end

  // ****************************************************************
  // start-up sequence
  // ****************************************************************
  seq_e seq_r;
  logic [7:0] vec_lo_r;
  logic [15:0] pc_r;
  logic pc_load_r;

  always_ff @(posedge CLK) begin
    if (rst_any) begin
      seq_r <= SEQ_RESET;
    end else begin
      case (seq_r)
        SEQ_RESET: seq_r <= SEQ_VEC_LO;
        SEQ_VEC_LO: seq_r <= SEQ_VEC_HI;
        SEQ_VEC_HI: seq_r <= SEQ_RUN;
        SEQ_RUN: seq_r <= SEQ_RUN;
        default: seq_r <= SEQ_RESET;
      endcase
    end
  end

  // memory answers one cycle after the read address
  assign MEM_RD = !rst_any && (seq_r == SEQ_RESET || seq_r == SEQ_VEC_LO);
  assign MEM_ADDR = (seq_r == SEQ_RESET) ? VEC_ADDR_LO : VEC_ADDR_HI;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      vec_lo_r <= '0;
      pc_r <= '0;
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= !rst_any && seq_r == SEQ_VEC_HI;
      if (!rst_any && seq_r == SEQ_VEC_LO) begin
        vec_lo_r <= MEM_RDATA;
      end
      if (!rst_any && seq_r == SEQ_VEC_HI) begin
        pc_r <= {MEM_RDATA, vec_lo_r};
      end
    end
  end
  assign PC = pc_r;
  assign PC_LOAD = pc_load_r;

  // ****************************************************************
  // clocks and pin modes
  // ****************************************************************
  logic [15:0] clkc;
  assign clkc = regs_r[IDX_CLK_CTRL];

  assign CLK_CTL.cpu_en = !rst_any && seq_r == SEQ_RUN;
  assign CLK_CTL.cpu_fast = 1'b1;
  assign CLK_CTL.fast_en = !rst_any;
  assign CLK_CTL.slow_en = !rst_any;
  assign CLK_CTL.xtal_en = !rst_any && clkc[CLKC_XTAL_BIT];
  assign CLK_CTL.xtal_port = rst_any || !clkc[CLKC_XTAL_BIT];
  assign CLK_CTL.extclk_port = rst_any || !clkc[CLKC_EXT_BIT];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  AST_CPU_GATED: assert property (rst_any |-> !CLK_CTL.cpu_en)
    else $error("core clock runs during reset");
  AST_OSC_HALT: assert property (rst_any |-> !CLK_CTL.fast_en && !CLK_CTL.slow_en
      && !CLK_CTL.xtal_en && CLK_CTL.xtal_port)
    else $error("oscillator active during reset");
  AST_EXTCLK_PORT: assert property (rst_any |-> CLK_CTL.extclk_port)
    else $error("external clock pin not port in reset");
  AST_VEC_LOAD: assert property ($fell(rst_any) && seq_r == SEQ_RESET
      |-> MEM_RD && MEM_ADDR == VEC_ADDR_LO ##1 MEM_ADDR == VEC_ADDR_HI
      ##2 PC_LOAD && PC == {$past(MEM_RDATA, 1), $past(MEM_RDATA, 2)})
    else $error("pc not loaded from vector");
  AST_PORT_CLR: assert property (rst_any |=> PORT_OUT == 40'h00_0000_0000)
    else $error("port latch not cleared");
  AST_MEMSZ: assert property (rst_any |=> regs_r[IDX_MEMSZ] == RV_MEMSZ)
    else $error("memory size select wrong after reset");
  AST_WIDE_TIMER: assert property (rst_any |=> regs_r[IDX_WT_CNT] == RV_ZERO
      && regs_r[IDX_WT_CCB] == RV_ZERO && regs_r[IDX_WT_OUT] == RV_ZERO)
    else $error("wide timer not cleared");
  AST_WATCHDOG_ENABLE_REG: assert property (rst_any |=> regs_r[IDX_WATCHDOG_ENABLE_REG]
      == ($past(WDT_OPTION) ? RV_WATCHDOG_ENABLE_REG_OPT1 : RV_WATCHDOG_ENABLE_REG_OPT0))
    else $error("watchdog enable reset value wrong");
  AST_SER_BUF: assert property (rst_any |=> regs_r[IDX_SER_RXB] == RV_ONES
      && regs_r[IDX_SER_TXB] == RV_ONES)
    else $error("serial buffers not all ones");
  AST_SER_CTRL: assert property (rst_any |=> regs_r[IDX_SER_MODE] == RV_SER_MODE
      && regs_r[IDX_SER_BAUD] == RV_ONES && regs_r[IDX_SER_CTRL] == RV_SER_CTRL)
    else $error("serial control reset values wrong");
  AST_IRQ_INIT: assert property (rst_any |=> regs_r[IDX_IRQ_REQ] == RV_ZERO
      && regs_r[IDX_IRQ_MASK] == RV_ONES && regs_r[IDX_IRQ_PRIO] == RV_ONES)
    else $error("interrupt flags not initialised");
  AST_CAUSE_WDT: assert property (rst_any && RST_SRC.wdt && !rst_clr_cause
      |=> regs_r[IDX_RESET_CAUSE_FLAGS][RESET_CAUSE_FLAGS_WDT_BIT])
    else $error("watchdog cause flag not set");
  AST_LVI_HOLD: assert property (rst_any && !rst_hard
      |=> regs_r[IDX_UNDERVOLT_DETECT_CTRL] == $past(regs_r[IDX_UNDERVOLT_DETECT_CTRL]))
    else $error("undervoltage control lost on its own reset");
  AST_CAUSE_RDCLR: assert property (rd_clr && !rst_any |=> regs_r[IDX_RESET_CAUSE_FLAGS] == RV_ZERO
      && rvalid_r)
    else $error("cause register not cleared by read");
  AST_RUN_FAST: assert property (CLK_CTL.cpu_en |-> CLK_CTL.cpu_fast
      && CLK_CTL.fast_en)
    else $error("core not on fast oscillator");

endmodule : reset_state_initializer

// ### reset_state_pkg.sv
// constants, register map and reset values of the reset state initializer
// ****************************************************************
// ****************************************************************
package reset_state_pkg;

  localparam int NREG = 51;
  localparam int IDX_W = 6;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_MEMSZ = 6'h00;
  localparam logic [5:0] IDX_WATCHDOG_ENABLE_REG = 6'h01;
  localparam logic [5:0] IDX_RESET_CAUSE_FLAGS = 6'h02;
  localparam logic [5:0] IDX_UNDERVOLT_DETECT_CTRL = 6'h03;
  localparam logic [5:0] IDX_UNDERVOLT_LEVEL_SELECT = 6'h04;
  localparam logic [5:0] IDX_RAM_RETENTION_DETECT_CTRL = 6'h05;
  localparam logic [5:0] IDX_RSTMODE = 6'h06;
  localparam logic [5:0] IDX_WT_CNT = 6'h07;
  localparam logic [5:0] IDX_WT_CCB = 6'h09;
  localparam logic [5:0] IDX_WT_OUT = 6'h0D;
  localparam logic [5:0] IDX_EC_FIRST = 6'h0E;
  localparam logic [5:0] IDX_EC_LAST = 6'h15;
  localparam logic [5:0] IDX_IT_FIRST = 6'h16;
  localparam logic [5:0] IDX_IT_LAST = 6'h1C;
  localparam logic [5:0] IDX_SER_RXB = 6'h1D;
  localparam logic [5:0] IDX_SER_TXB = 6'h1E;
  localparam logic [5:0] IDX_SER_MODE = 6'h1F;
  localparam logic [5:0] IDX_SER_ERR = 6'h20;
  localparam logic [5:0] IDX_SER_TXST = 6'h21;
  localparam logic [5:0] IDX_SER_CKSEL = 6'h22;
  localparam logic [5:0] IDX_SER_BAUD = 6'h23;
  localparam logic [5:0] IDX_SER_CTRL = 6'h24;
  localparam logic [5:0] IDX_ISC = 6'h25;
  localparam logic [5:0] IDX_IRQ_REQ = 6'h26;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h27;
  localparam logic [5:0] IDX_IRQ_PRIO = 6'h28;
  localparam logic [5:0] IDX_EDGE_RISE = 6'h29;
  localparam logic [5:0] IDX_EDGE_FALL = 6'h2A;
  localparam logic [5:0] IDX_PORT0 = 6'h2B;
  localparam logic [5:0] IDX_PORT4 = 6'h2F;
  localparam logic [5:0] IDX_KEY_LO = 6'h30;
  localparam logic [5:0] IDX_KEY_HI = 6'h31;
  localparam logic [5:0] IDX_CLK_CTRL = 6'h32;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int RESET_CAUSE_FLAGS_LVI_BIT = 0;
  localparam int RESET_CAUSE_FLAGS_WDT_BIT = 4;
  localparam int CLKC_XTAL_BIT = 0;
  localparam int CLKC_EXT_BIT = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RV_ZERO = 16'h0000;
  localparam logic [15:0] RV_ONES = 16'h00FF;
  localparam logic [15:0] RV_MEMSZ = 16'h00CF;
  localparam logic [15:0] RV_WATCHDOG_ENABLE_REG_OPT0 = 16'h001A;
  localparam logic [15:0] RV_WATCHDOG_ENABLE_REG_OPT1 = 16'h009A;
  localparam logic [15:0] RV_SER_MODE = 16'h0001;
  localparam logic [15:0] RV_SER_CTRL = 16'h0016;
  localparam logic [15:0] MASK_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0000;
  localparam logic [15:0] VEC_ADDR_HI = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEQ_RESET, SEQ_VEC_LO, SEQ_VEC_HI, SEQ_RUN} seq_e;

  typedef struct packed {
    logic pin_n;
    logic power_on_clear;
    logic wdt;
    logic undervoltage_detector;
  } rst_src_s;

  typedef struct packed {
    logic cpu_en;
    logic cpu_fast;
    logic fast_en;
    logic xtal_en;
    logic slow_en;
    logic xtal_port;
    logic extclk_port;
  } clk_ctl_s;

  function automatic logic [15:0] rst_val(input logic [5:0] idx, input logic wdt_opt);
    logic [15:0] v;
    v = RV_ZERO;
    case (idx)
      IDX_MEMSZ: v = RV_MEMSZ;
      IDX_WATCHDOG_ENABLE_REG: v = wdt_opt ? RV_WATCHDOG_ENABLE_REG_OPT1 : RV_WATCHDOG_ENABLE_REG_OPT0;
      IDX_SER_RXB, IDX_SER_TXB, IDX_SER_BAUD: v = RV_ONES;
      IDX_SER_MODE: v = RV_SER_MODE;
      IDX_SER_CTRL: v = RV_SER_CTRL;
      IDX_IRQ_MASK, IDX_IRQ_PRIO: v = RV_ONES;
      default: v = RV_ZERO;
    endcase
    return v;
  endfunction : rst_val

  function automatic logic [15:0] reg_mask(input logic [5:0] idx);
    return (idx >= IDX_WT_CNT && idx <= IDX_WT_CCB) ? MASK_WORD : MASK_BYTE;
  endfunction : reg_mask

endpackage : reset_state_pkg

// ### test_reset_state_initializer.sv
// testbench of the reset state initializer
`timescale 1ns/1ps
module test_reset_state_initializer
  import reset_state_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam rst_src_s IDLE = 4'b1000;
  logic clk = 0, nrst = 0, wdt_opt = 0, stby = 0, pc_load, sys_rst, ram_keep, mem_rd;
  rst_src_s src = IDLE;
  clk_ctl_s ctl;
  logic [15:0] mem_addr, pc;
  logic [7:0] mem_rdata;
  logic [39:0] port_out;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic [1:0] bresp, rresp, resp_q;
  int n_errors = 0, tests_run = 0, cycles = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  reset_state_initializer uut (.CLK(clk), .NRST(nrst), .RST_SRC(src), .WDT_OPTION(wdt_opt),
    .STANDBY(stby), .CLK_CTL(ctl), .SYS_RESET(sys_rst), .RAM_PRESERVE(ram_keep),
    .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .PC(pc), .PC_LOAD(pc_load),
    .PORT_OUT(port_out), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  vector_rom rom (.CLK(clk), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task test_done;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 30000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end

  task chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wr(input int idx, input logic [15:0] d);
    @(posedge clk);
    awaddr <= 8'(idx * 4);
    wdata <= {16'h0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    resp_q = bresp;
    bready <= 0;
  endtask : wr

  task rd(input int idx);
    @(posedge clk);
    araddr <= 8'(idx * 4);
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 0;
  endtask : rd

  task rdchk(input int idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_q, exp);
    chk(resp_q, RESP_OKAY);
  endtask : rdchk

  // waits for the vector load after a release; reset holds the core clock off
  task rel_chk;
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(pc, 16'h1234);
    @(posedge clk);
    #1;
    chk({ctl.cpu_en, ctl.cpu_fast}, 2'b11);
  endtask : rel_chk

  task rst(input rst_src_s s);
    @(posedge clk);
    src <= s;
    repeat (2) @(posedge clk);
    #1;
    chk(sys_rst, 1);
    chk(ctl.cpu_en, 0);
    chk({ctl.fast_en, ctl.xtal_en, ctl.slow_en, ctl.xtal_port}, 4'b0001);
    chk(ctl.extclk_port, 1);
    chk(pc_load, 0);
    @(posedge clk);
    src <= IDLE;
    rel_chk();
  endtask : rst

  function automatic logic [31:0] exp_rv(input int i, input logic opt);
    case (i)
      0: return 32'h0000_00CF;
      1: return opt ? 32'h0000_009A : 32'h0000_001A;
      29, 30, 35, 39, 40: return 32'h0000_00FF;
      31: return 32'h0000_0001;
      36: return 32'h0000_0016;
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rv

  task table_chk;
    for (int i = 0; i < 51; i++) begin
      if (i != 2 && i != 5) rdchk(i, exp_rv(i, wdt_opt));
    end
  endtask : table_chk

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    rel_chk();
    table_chk();
    rd(51);
    chk(resp_q, RESP_SLVERR);
    for (int i = 0; i < 51; i++) wr(i, 16'hA5A5);
    wr(51, 16'h1111);
    chk(resp_q, RESP_SLVERR);
    wr(0, 16'h0041);
    chk(resp_q, RESP_OKAY);
    rdchk(0, 32'h0000_0041);
    rdchk(8, 32'h0000_A5A5);
    #1;
    chk(port_out, {5{8'hA5}});
    chk({ctl.xtal_en, ctl.xtal_port, ctl.extclk_port}, 3'b101);
    rst(4'b0000);
    chk(port_out, 40'h0);
    table_chk();
    rst(4'b1010);
    rdchk(2, 32'h0000_0010);
    rdchk(2, 32'h0000_0000);
    wr(3, 16'h0055);
    rst(4'b1010);
    rst(4'b1001);
    rdchk(2, 32'h0000_0011);
    rdchk(3, 32'h0000_0000);
    wr(3, 16'h0055);
    wr(4, 16'h0033);
    rst(4'b1001);
    rdchk(3, 32'h0000_0055);
    rdchk(4, 32'h0000_0033);
    rst(4'b1100);
    rdchk(2, 32'h0000_0000);
    rdchk(3, 32'h0000_0000);
    wdt_opt <= 1;
    stby <= 1;
    rst(4'b0000);
    rdchk(1, 32'h0000_009A);
    chk(ram_keep, 1);
    wdt_opt <= 0;
    stby <= 0;
    rst(4'b0000);
    chk(ram_keep, 0);
    rdchk(1, 32'h0000_001A);
    test_done();
  end
endmodule : test_reset_state_initializer

// ### vector_rom.sv
// vector memory model answering the reset vector fetch
`timescale 1ns/1ps
module vector_rom #(
  parameter logic [7:0] VEC_LO = 8'h34,
  parameter logic [7:0] VEC_HI = 8'h12
) (
  input wire logic CLK,
  input wire logic MEM_RD,
  input wire logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_RDATA
);
  // ****************************************************************
  // read port
  // ****************************************************************
  initial MEM_RDATA = 8'h5A;
  // vector bytes
  // data comes one cycle after the read; otherwise the bus toggles so no stale byte passes
  always @(posedge CLK) begin
    if (MEM_RD && MEM_ADDR == 16'h0000) begin
      MEM_RDATA <= VEC_LO;
    end else if (MEM_RD && MEM_ADDR == 16'h0001) begin
      MEM_RDATA <= VEC_HI;
    end else begin
      MEM_RDATA <= ~MEM_RDATA;
    end
  end
endmodule : vector_rom
